// ### hdl/sleep_pkg.sv
package sleep_pkg;
	// Clock rate in Hz.
	localparam int unsigned CLOCK_HZ = 50000000;
	// Internal tick period in microseconds and its cycle count.
	localparam int unsigned TICK_US = 1000;
	localparam int unsigned TICK_CYCLES = CLOCK_HZ / 1000000 * TICK_US;
	// Sleep mode select codes.
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [3:0] MODE_PIN = 4'h1;
	localparam logic [3:0] MODE_CYC_LO = 4'h4;
	localparam logic [3:0] MODE_CYC_HI = 4'h8;
	// Listen windows in milliseconds for each radio rate setting.
	localparam int unsigned LISTEN_FAST_MS = 35;
	localparam int unsigned LISTEN_SLOW_MS = 225;
	// Shortest cyclic interval in milliseconds; each code step doubles it.
	localparam int unsigned CYC_BASE_MS = 1000;
	// Width of the millisecond counters.
	localparam int unsigned MS_W = 16;
	// Reset values.
	localparam logic [3:0] MODE_RESET = 4'h0;
	localparam logic [MS_W-1:0] WAKE_RESET = 16'h0BB8;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_BUSY,
		ST_PIN_SLEEP,
		ST_CYC_SLEEP,
		ST_LISTEN
	} sleep_state_t;
endpackage

// ### hdl/sleep_link_if.sv
interface sleep_link_if;
	// Host drives sleep request high to ask for sleep.
	logic sleep_req;
	// Device outputs: active-low clear to send and power indicator.
	logic clear_to_send_n;
	logic transmit_power_indicator;
	// Host sends a serial byte start strobe, so the device sees activity.
	logic host_byte_start;

	modport device (
		input sleep_req,
		input host_byte_start,
		output clear_to_send_n,
		output transmit_power_indicator
	);
	modport host (
		output sleep_req,
		output host_byte_start,
		input clear_to_send_n,
		input transmit_power_indicator
	);
endinterface

// ### hdl/sleep_mode_controller.sv
// How it works
// - Zero sleep mode never sleeps.
// - Cyclic modes sleep after idle for wake time.
// - Sleeping blocks all activity until it wakes.
// - Pin high sleeps, pin low wakes.
// - Pin starts sleep only in pin sleep mode.
// - Finish transfer before pin sleep.
// - Clear to send high in pin sleep.
// - Power indicator low in pin sleep.
// - Host waits for second byte start.
// - Codes four to eight pick 1-16 seconds.
// - Listen window 35 or 225 ms.
// - No data sleeps again, data receives.
// - Initializer detected leads to receive.
// - Cyclic sleep holds clear to send high.
// - Power indicator low in cyclic sleep.
// - Resleep after wake time inactivity.
// - Pin wake forces idle in cyclic.
// - Cyclic interval shorter than initializer.
module sleep_mode_controller (
	// Clock and reset.
	input wire logic clock,
	input wire logic srst,
	// Link to the host.
	sleep_link_if.device link,
	// Configuration.
	input wire logic [3:0] sleep_mode_select,
	input wire logic [sleep_pkg::MS_W-1:0] wake_time_setting,
	input wire logic pin_wakeup_enable,
	input wire logic radio_rate_setting,
	// Radio and serial activity from the datapath.
	input wire logic transfer_active,
	input wire logic valid_data_seen,
	// Status and gating.
	output logic asleep,
	output logic activity_allowed
);
	sleep_pkg::sleep_state_t state_ff, nxt_state;
	// Tick divider width and the count at which it wraps.
	localparam int unsigned TICK_W = $clog2(sleep_pkg::TICK_CYCLES);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(sleep_pkg::TICK_CYCLES - 1);
	logic [TICK_W-1:0] tick_cnt_ff;
	logic tick;
	logic [sleep_pkg::MS_W-1:0] ms_cnt_ff;
	logic [sleep_pkg::MS_W-1:0] cyc_limit;
	logic [sleep_pkg::MS_W-1:0] listen_limit;
	logic is_cyclic;
	logic restart;
	logic activity;
	logic pin_sleep_go;
	logic cyc_sleep_go;
	logic cyc_expired;
	logic listen_done;
	logic pin_release;
	logic sleeping_next;

	// Selects the cyclic interval from the mode code.
	function automatic logic [sleep_pkg::MS_W-1:0] cyc_ms(input logic [3:0] code);
		logic [3:0] step;
		step = code - sleep_pkg::MODE_CYC_LO;
		cyc_ms = sleep_pkg::MS_W'(sleep_pkg::CYC_BASE_MS) << step;
	endfunction

	// True for either sleep state; every pin output decodes it.
	function automatic logic is_sleep(input sleep_pkg::sleep_state_t st);
		is_sleep = (st == sleep_pkg::ST_PIN_SLEEP) || (st == sleep_pkg::ST_CYC_SLEEP);
	endfunction

	// Codes four to eight are the cyclic modes.
	assign is_cyclic = (sleep_mode_select >= sleep_pkg::MODE_CYC_LO) &&
		(sleep_mode_select <= sleep_pkg::MODE_CYC_HI);
	// Sleep interval for the selected cyclic code.
	assign cyc_limit = cyc_ms(sleep_mode_select);
	// Listen window for the radio rate in use.
	assign listen_limit = radio_rate_setting ?
		sleep_pkg::MS_W'(sleep_pkg::LISTEN_FAST_MS) :
		sleep_pkg::MS_W'(sleep_pkg::LISTEN_SLOW_MS);
	// Anything moving on the radio or the serial side.
	assign activity = transfer_active || link.host_byte_start || valid_data_seen;
	// The millisecond counter restarts on every state change and on activity while busy.
	assign restart = (state_ff != nxt_state) ||
		((state_ff == sleep_pkg::ST_BUSY) && activity);

	// The pin only starts sleep in pin sleep mode; no other mode sleeps on it.
	assign pin_sleep_go = (sleep_mode_select == sleep_pkg::MODE_PIN) && link.sleep_req;

	// Quiet for the wake time; only the cyclic modes use this timeout.
	assign cyc_sleep_go = is_cyclic && (ms_cnt_ff >= wake_time_setting);

	// Sleep interval used up, so the device wakes to listen.
	assign cyc_expired = ms_cnt_ff >= cyc_limit;

	// Listen window closed with no valid packet.
	assign listen_done = ms_cnt_ff >= listen_limit;

	// A released pin cuts cyclic sleep short only with pin wake-up on.
	assign pin_release = pin_wakeup_enable && !link.sleep_req;

	// The next state is a sleep state; every pin output follows this.
	assign sleeping_next = is_sleep(nxt_state);

	// Shared millisecond tick for every interval.
	always_ff @(posedge clock) begin
		if (srst || tick) begin
			tick_cnt_ff <= '0;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 1'b1;
		end
	end
	// One-cycle strobe at the end of each millisecond.
	assign tick = (tick_cnt_ff == TICK_LAST);

	// Millisecond counter restarted on each state change or on activity while busy.
	always_ff @(posedge clock) begin
		if (srst || restart) begin
			ms_cnt_ff <= '0;
		end else if (tick && ms_cnt_ff != '1) begin
			ms_cnt_ff <= ms_cnt_ff + 1'b1;
		end
	end

	// Next state decision.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			// Awake and quiet: a transfer, the pin or the idle timeout moves on.
			sleep_pkg::ST_IDLE: begin
				if (activity) begin
					nxt_state = sleep_pkg::ST_BUSY;
				end else if (pin_sleep_go) begin
					nxt_state = sleep_pkg::ST_PIN_SLEEP;
				end else if (cyc_sleep_go) begin
					nxt_state = sleep_pkg::ST_CYC_SLEEP;
				end
			end
			sleep_pkg::ST_BUSY: begin
				// Any transfer in progress finishes before sleep is considered.
				if (!activity) begin
					nxt_state = sleep_pkg::ST_IDLE;
				end
			end
			// Pin low, or a mode change, brings the device back to idle.
			sleep_pkg::ST_PIN_SLEEP: begin
				if (!link.sleep_req || sleep_mode_select != sleep_pkg::MODE_PIN) begin
					nxt_state = sleep_pkg::ST_IDLE;
				end
			end
			// Sleeping on the interval timer; the pin may cut it short.
			sleep_pkg::ST_CYC_SLEEP: begin
				if (!is_cyclic) begin
					nxt_state = sleep_pkg::ST_IDLE;
				end else if (pin_release) begin
					nxt_state = sleep_pkg::ST_IDLE;
				end else if (cyc_expired) begin
					nxt_state = sleep_pkg::ST_LISTEN;
				end
			end
			// Awake to listen; valid data or any other activity means receive.
			sleep_pkg::ST_LISTEN: begin
				if (activity) begin
					nxt_state = sleep_pkg::ST_BUSY;
				end else if (listen_done) begin
					nxt_state = sleep_pkg::ST_CYC_SLEEP;
				end
			end
			default: nxt_state = sleep_pkg::ST_IDLE;
		endcase
		// Mode zero forces idle unless a transfer is still running.
		if (sleep_mode_select == sleep_pkg::MODE_OFF && state_ff != sleep_pkg::ST_BUSY) begin
			nxt_state = sleep_pkg::ST_IDLE;
		end
	end

	// State register.
	always_ff @(posedge clock) begin
		if (srst) begin
			state_ff <= sleep_pkg::ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Clear to send is held high while either sleep state lasts.
	always_ff @(posedge clock) begin
		if (srst) begin
			link.clear_to_send_n <= 1'b0;
		end else begin
			link.clear_to_send_n <= sleeping_next;
		end
	end

	// Power indicator goes low while either sleep state lasts.
	always_ff @(posedge clock) begin
		if (srst) begin
			link.transmit_power_indicator <= 1'b1;
		end else begin
			link.transmit_power_indicator <= !sleeping_next;
		end
	end

	// Sleep status that gates the datapath.
	always_ff @(posedge clock) begin
		if (srst) begin
			asleep <= 1'b0;
		end else begin
			asleep <= sleeping_next;
		end
	end

	// Datapath may run only when not asleep.
	assign activity_allowed = !asleep;
endmodule

// ### hdl/sleep_host.sv
module sleep_host (
	// Clock and reset.
	input wire logic clock,
	input wire logic srst,
	// Link to the device.
	sleep_link_if.host link,
	// User side.
	input wire logic want_sleep,
	input wire logic byte_start,
	output logic may_send,
	output logic device_powered
);
	logic [1:0] bytes_ff;

	// Counts bytes really sent, not held-off ones, since sleep was last dropped.
	always_ff @(posedge clock) begin
		if (srst || !want_sleep) begin
			bytes_ff <= 2'h0;
		end else if (link.host_byte_start && bytes_ff != 2'h3) begin
			bytes_ff <= bytes_ff + 2'h1;
		end
	end

	// Sleep is requested only after the second byte began.
	always_ff @(posedge clock) begin
		if (srst) begin
			link.sleep_req <= 1'b0;
		end else begin
			link.sleep_req <= want_sleep && (bytes_ff >= 2'h2);
		end
	end

	// Byte start reaches the device only while clear to send is low.
	assign link.host_byte_start = byte_start && !link.clear_to_send_n;
	assign may_send = !link.clear_to_send_n;
	assign device_powered = link.transmit_power_indicator;
endmodule

// ### bench/sleep_link_props.sv
module sleep_link_props (
	// Clock and reset.
	input wire logic clock,
	input wire logic srst,
	// Link signals.
	input wire logic sleep_req,
	input wire logic host_byte_start,
	input wire logic clear_to_send_n,
	input wire logic transmit_power_indicator
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] starts_ff;
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	// Counts byte starts while no request stands, saturating at two.
	always_ff @(posedge clock) begin
		if (srst || sleep_req) begin
			starts_ff <= 2'h0;
		end else if (host_byte_start && starts_ff != 2'h2) begin
			starts_ff <= starts_ff + 2'h1;
		end
	end
	// Link behaviour while asleep, on wake and around reset.
	property p_pair; clear_to_send_n == !transmit_power_indicator; endproperty
	property p_hold_off; clear_to_send_n |-> !host_byte_start; endproperty
	property p_order; $rose(sleep_req) |-> starts_ff == 2'h2; endproperty
	property p_wake; $fell(sleep_req) |-> ##[1:2] !clear_to_send_n; endproperty
	property p_reset;
		disable iff (1'h0) srst |=> !clear_to_send_n && transmit_power_indicator;
	endproperty
	a_pair: assert property (p_pair) else $error("power and cts disagree");
	a_hold_off: assert property (p_hold_off) else $error("byte sent while held off");
	a_order: assert property (p_order) else $error("request before second byte");
	a_wake: assert property (p_wake) else $error("no wake after release");
	property p_req_reset;
		disable iff (1'h0) srst |=> !sleep_req;
	endproperty
	a_reset: assert property (p_reset) else $error("wrong link state in reset");
	a_req_reset: assert property (p_req_reset) else $error("sleep request after reset");
	c_sleep: cover property ($rose(clear_to_send_n));
	c_wake: cover property ($fell(clear_to_send_n));
	c_req: cover property ($rose(sleep_req));
endmodule

// ### bench/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [3:0] mode; logic want; logic exp_sleep;} row_t;
	logic clock = 1'h0;
	logic srst = 1'h1;
	logic [3:0] mode = 4'h0;
	logic want = 1'h0;
	logic xfer = 1'h0;
	logic rx = 1'h0;
	logic byte_start = 1'h0;
	logic asleep;
	logic allowed;
	logic may_send;
	logic powered;
	int err_count = 0;
	int checks = 0;
	row_t rows[6] = '{'{sleep_pkg::MODE_OFF, 1'h1, 1'h0}, '{sleep_pkg::MODE_PIN, 1'h1, 1'h1},
		'{4'h2, 1'h1, 1'h0}, '{sleep_pkg::MODE_CYC_LO, 1'h1, 1'h0},
		'{sleep_pkg::MODE_CYC_HI, 1'h1, 1'h0}, '{sleep_pkg::MODE_PIN, 1'h0, 1'h0}};
	sleep_link_if link ();
	// Both ends joined across the link, with the checker beside it.
	sleep_mode_controller i_sleep_mode_controller (.clock(clock), .srst(srst),
		.link(link.device), .sleep_mode_select(mode), .wake_time_setting(sleep_pkg::WAKE_RESET),
		.pin_wakeup_enable(1'h1), .radio_rate_setting(1'h1), .transfer_active(xfer),
		.valid_data_seen(rx), .asleep(asleep), .activity_allowed(allowed));
	sleep_host i_sleep_host (.clock(clock), .srst(srst), .link(link.host), .want_sleep(want),
		.byte_start(byte_start), .may_send(may_send), .device_powered(powered));
	sleep_link_props i_sleep_link_props (.clock(clock), .srst(srst),
		.sleep_req(link.sleep_req), .host_byte_start(link.host_byte_start),
		.clear_to_send_n(link.clear_to_send_n),
		.transmit_power_indicator(link.transmit_power_indicator));
	// Free-running clock.
	always #10 clock = ~clock;
	// Compares one bit and reports a mismatch.
	task chk(input string name, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %b seen %b", name, exp, got);
		end
	endtask
	// Sends byte start pulses one cycle wide.
	task pulses(input int n);
		for (int k = 0; k < n; k++) begin
			@(posedge clock) byte_start <= 1'h1;
			@(posedge clock) byte_start <= 1'h0;
		end
	endtask
	// Lets the request cross both ends, then checks every sleep output.
	task settle_chk(input logic exp);
		repeat (4) @(posedge clock);
		#1;
		chk("asleep", exp, asleep);
		chk("allowed", !exp, allowed);
		chk("cts_n", exp, link.clear_to_send_n);
		chk("tx_power", !exp, link.transmit_power_indicator);
		chk("may_send", !exp, may_send);
		chk("powered", !exp, powered);
		@(posedge clock);
	endtask
	// Prints the counts and the verdict.
	task tally_and_finish;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Table rows first, then transfer hold-off and release, short byte count, mid-run reset and sleep again.
	initial begin
		repeat (12) @(posedge clock);
		srst <= 1'h0;
		settle_chk(1'h0);
		foreach (rows[i]) begin
			mode <= rows[i].mode;
			want <= rows[i].want;
			pulses(2);
			settle_chk(rows[i].exp_sleep);
			want <= 1'h0;
			settle_chk(1'h0);
		end
		mode <= sleep_pkg::MODE_PIN;
		xfer <= 1'h1;
		rx <= 1'h1;
		want <= 1'h1;
		pulses(2);
		settle_chk(1'h0);
		xfer <= 1'h0;
		settle_chk(1'h0);
		rx <= 1'h0;
		settle_chk(1'h1);
		want <= 1'h0;
		settle_chk(1'h0);
		want <= 1'h1;
		pulses(1);
		settle_chk(1'h0);
		pulses(1);
		settle_chk(1'h1);
		srst <= 1'h1;
		settle_chk(1'h0);
		srst <= 1'h0;
		settle_chk(1'h0);
		pulses(2);
		settle_chk(1'h1);
		tally_and_finish();
	end
endmodule
